/* crcs_bus_model.sv */
// processor and dma bus master model that feeds the snoop port
`timescale 1ns/1ps
`default_nettype none
`include "crcs_map.svh"

module crcs_bus_model (
	input wire logic i_clk, // system clock
	input wire logic i_go, // request one access
	input wire logic i_write, // 1 write, 0 read
	input wire logic [`CRCS_ADDR_W-1:0] i_addr, // access address
	input wire logic [15:0] i_data, // word written or returned
	output var logic o_bus_valid = 1'b0, // one cycle per access
	output var logic o_bus_write = 1'b0, // direction
	output var logic [`CRCS_ADDR_W-1:0] o_bus_addr = 14'h0000, // address
	output var logic [15:0] o_bus_wdata = 16'h0000, // write data
	output var logic [15:0] o_bus_rdata = 16'h0000 // read data
);
	// one-cycle access a cycle after the request
	// released data lines flip each cycle so stale data cannot match
	always @(posedge i_clk) begin
		o_bus_valid <= i_go;
		o_bus_write <= i_write;
		o_bus_addr <= i_addr;
		o_bus_wdata <= (i_go && i_write) ? i_data : ~o_bus_wdata;
		o_bus_rdata <= (i_go && !i_write) ? i_data : ~o_bus_rdata;
	end
endmodule // crcs_bus_model
`default_nettype wire

/* crcs_calc_if.sv */
// carrier between the crc sequencer and its byte engine
`timescale 1ns/1ps
`default_nettype none

interface crcs_calc_if;
	logic [15:0] crc_in; // previous result
	logic [7:0] data; // byte to fold in
	crcs_pkg::crcs_poly_t poly_sel; // polynomial choice
	logic [15:0] crc_out; // updated code

	modport seq (output crc_in, output data, output poly_sel, input crc_out);
	modport eng (input crc_in, input data, input poly_sel, output crc_out);
endinterface

`default_nettype wire

/* crcs_engine.sv */
// combinational one-byte crc step for either polynomial
`timescale 1ns/1ps
`default_nettype none
`include "crcs_map.svh"

module crcs_engine (
	crcs_calc_if.eng calc
);

	// polynomial mask chosen once per byte
	logic [15:0] poly;
	// running remainder inside the bit loop
	logic [15:0] rem;
	// feedback bit of the current step
	logic fb;

	// msb-first shift, data bit 7 first; both polynomials share it
	always_comb begin
		poly = (calc.poly_sel == crcs_pkg::CRCS_SEL_CRC16) ?
			`CRCS_POLY_CRC16 : `CRCS_POLY_CCITT; // R01
		rem = calc.crc_in;
		fb = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			fb = rem[15] ^ calc.data[i];
			rem = {rem[14:0], 1'b0} ^ (fb ? poly : 16'h0000); // R01
		end
		calc.crc_out = rem;
	end

endmodule // crcs_engine

`default_nettype wire

/* crcs_map.svh */
// offsets, bit positions, reset values and timing counts of the crc block
`ifndef CRCS_MAP_SVH
`define CRCS_MAP_SVH

// snoop target register layout
`define CRCS_TGT_WR_EN_BIT 15
`define CRCS_TGT_RD_EN_BIT 14
`define CRCS_TGT_ADDR_MSB 13
`define CRCS_ADDR_W 14

// highest address that may never be snooped; capture needs strictly above
`define CRCS_SNOOP_FLOOR 14'h0020

// generator polynomials, x^16 term implied
`define CRCS_POLY_CCITT 16'h1021
`define CRCS_POLY_CRC16 16'h8005

// reset values
`define CRCS_RST_BYTE 8'h00
`define CRCS_RST_RESULT 16'h0000
`define CRCS_RST_TARGET 16'h0000

// machine cycles from byte arrival to valid result
`define CRCS_CALC_CYCLES 2

`endif

/* crcs_pkg.sv */
// types shared by the crc calculator modules
package crcs_pkg;

	// calculation sequencer, one-hot
	typedef enum logic [1:0] {
		CRCS_IDLE = 2'b01,
		CRCS_CALC = 2'b10
	} crcs_state_t;

	// polynomial choice
	typedef enum logic {
		CRCS_SEL_CCITT = 1'b0,
		CRCS_SEL_CRC16 = 1'b1
	} crcs_poly_t;

endpackage

/* crcs_top.sv */
// crc-16 / ccitt calculator with explicit byte input and bus snooping
//
// Contract
// (R01) polynomial selectable: CCITT or CRC-16
// (R02) sixteen-bit code over whole bytes
// (R03) each input byte folds into result
// (R04) software seeds result before each calculation
// (R05) byte processed within two machine cycles
// (R06) snoop only addresses above 0020h
// (R07) target register: address plus read/write enables
// (R08) enabled write to target captures byte
// (R09) enabled read of target captures byte
// (R10) word access captures low byte only
// (R11) explicit input write beats snoop capture
// (R12) registers read back, zero after reset
`timescale 1ns/1ps
`default_nettype none
`include "crcs_map.svh"

module crcs_top (
	input wire logic i_clk, // system clock, 125 MHz
	input wire logic i_nrst, // async reset, active low
	input wire logic i_poly_sel, // 0 ccitt, 1 crc-16
	input wire logic i_in_wr, // explicit byte write strobe
	input wire logic [7:0] i_in_data, // explicit byte
	input wire logic i_res_wr, // result seed write strobe
	input wire logic [15:0] i_res_data, // seed value
	input wire logic i_tgt_wr, // snoop target write strobe
	input wire logic [15:0] i_tgt_data, // target value
	input wire logic i_bus_valid, // peripheral access this cycle
	input wire logic i_bus_write, // 1 write, 0 read
	input wire logic [`CRCS_ADDR_W-1:0] i_bus_addr, // peripheral address
	input wire logic [15:0] i_bus_wdata, // data written by master
	input wire logic [15:0] i_bus_rdata, // data returned to master
	output logic [7:0] o_byte_input, // input register readback
	output logic [15:0] o_result, // result register readback
	output logic [15:0] o_target, // snoop target readback
	output logic o_busy // byte being folded in
);

	// address match, shared by read and write snoop decode
	function automatic logic snoop_hit(
		input logic [`CRCS_ADDR_W-1:0] addr,
		input logic [15:0] tgt
	);
		snoop_hit = (addr > `CRCS_SNOOP_FLOOR) &&
			(addr == tgt[`CRCS_TGT_ADDR_MSB:0]); // R06
	endfunction

	// registered state
	logic [7:0] byte_r; // input register
	logic [7:0] byte_nxt;
	logic [15:0] result_r; // result register, sixteen bits
	logic [15:0] result_nxt;
	logic [15:0] target_r; // snoop target register
	logic [15:0] target_nxt;
	crcs_pkg::crcs_state_t st_r; // sequencer
	crcs_pkg::crcs_state_t st_nxt;
	crcs_pkg::crcs_poly_t poly_r; // polynomial latched with the byte
	crcs_pkg::crcs_poly_t poly_nxt;

	// decoded snoop events
	logic wr_hit; // enabled write to target
	logic rd_hit; // enabled read of target
	logic cap; // either capture
	logic [7:0] cap_byte; // captured low byte
	logic load; // input register takes a byte

	// link to the byte engine
	crcs_calc_if calc ();

	crcs_engine u_engine (
		.calc(calc.eng)
	);

	// engine sees the byte already held, so a byte per cycle pipelines
	assign calc.crc_in = result_r; // R03
	assign calc.data = byte_r;
	assign calc.poly_sel = poly_r;

	// snoop decode; masters other than this block drive the bus
	always_comb begin
		wr_hit = i_bus_valid && i_bus_write &&
			target_r[`CRCS_TGT_WR_EN_BIT] &&
			snoop_hit(i_bus_addr, target_r); // R07 R08
		rd_hit = i_bus_valid && !i_bus_write &&
			target_r[`CRCS_TGT_RD_EN_BIT] &&
			snoop_hit(i_bus_addr, target_r); // R07 R09
		cap = wr_hit || rd_hit;
		// only the low lane is taken, even on a word access
		cap_byte = i_bus_write ? i_bus_wdata[7:0] : i_bus_rdata[7:0]; // R10
		// explicit write wins; a colliding capture is dropped, not queued
		load = i_in_wr || cap; // R11
	end

	// next values of input register, target and polynomial
	always_comb begin
		byte_nxt = byte_r;
		poly_nxt = poly_r;
		target_nxt = target_r;
		if (i_in_wr) begin
			byte_nxt = i_in_data; // R11
		end else if (cap) begin
			byte_nxt = cap_byte; // R08 R09
		end
		if (load) begin
			poly_nxt = crcs_pkg::crcs_poly_t'(i_poly_sel); // R01
		end
		if (i_tgt_wr) begin
			target_nxt = i_tgt_data; // R07
		end
	end

	// next values of the sequencer and result
	always_comb begin
		st_nxt = st_r;
		result_nxt = result_r;
		unique case (st_r)
			crcs_pkg::CRCS_IDLE: begin
				// waiting for a byte
				if (load) begin
					st_nxt = crcs_pkg::CRCS_CALC; // R05
				end
			end
			crcs_pkg::CRCS_CALC: begin
				// fold held byte in; a new byte keeps us busy
				result_nxt = calc.crc_out; // R03 R05
				st_nxt = load ? crcs_pkg::CRCS_CALC : crcs_pkg::CRCS_IDLE;
			end
			default: begin
				// illegal one-hot code recovers to idle
				st_nxt = crcs_pkg::CRCS_IDLE;
			end
		endcase
		// seed write overrides a step in flight; software owns the seed
		if (i_res_wr) begin
			result_nxt = i_res_data; // R04
		end
	end

	// register stage; data registers cleared at reset, sequencer set to idle
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			byte_r <= `CRCS_RST_BYTE; // R12
			result_r <= `CRCS_RST_RESULT; // R12
			target_r <= `CRCS_RST_TARGET; // R12
			st_r <= crcs_pkg::CRCS_IDLE;
			poly_r <= crcs_pkg::CRCS_SEL_CCITT;
		end else begin
			byte_r <= byte_nxt;
			result_r <= result_nxt;
			target_r <= target_nxt;
			st_r <= st_nxt;
			poly_r <= poly_nxt;
		end
	end

	// readback straight from the registers
	assign o_byte_input = byte_r; // R12
	assign o_result = result_r; // R02 R12
	assign o_target = target_r; // R12
	assign o_busy = st_r[1];

	// a byte arrives with no seed write colliding in the same step
	sequence s_byte_arrives;
		load && !i_res_wr;
	endsequence

	// the following step folds it in
	sequence s_fold_step;
		o_busy && !i_res_wr;
	endsequence

	// arrival then fold then valid result, two cycles in all
	property p_two_cycle;
		@(posedge i_clk) disable iff (!i_nrst)
		s_byte_arrives ##1 s_fold_step |=>
			o_result == $past(calc.crc_out);
	endproperty

	a_two_cycle_result: assert property (p_two_cycle) // R05
		else $error("result not updated two cycles after byte");

	a_busy_after_load: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		load |=> o_busy) // R05
		else $error("busy not raised after byte load");

	a_busy_ends: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		o_busy && !load |=> !o_busy ##1 $stable(o_result) || i_res_wr
			|| $past(i_res_wr)) // R05
		else $error("busy stuck after calculation");

	a_low_addr_ignored: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_bus_valid && (i_bus_addr <= `CRCS_SNOOP_FLOOR) && !i_in_wr
		|=> $stable(o_byte_input)) // R06
		else $error("byte captured at a low address");

	a_write_capture: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		wr_hit && !i_in_wr |=>
			o_byte_input == $past(i_bus_wdata[7:0])) // R08 R10
		else $error("write snoop did not capture low byte");

	a_read_capture: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		rd_hit && !i_in_wr |=>
			o_byte_input == $past(i_bus_rdata[7:0])) // R09 R10
		else $error("read snoop did not capture low byte");

	a_write_disabled: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_bus_valid && i_bus_write && !o_target[`CRCS_TGT_WR_EN_BIT]
		&& !i_in_wr |=> $stable(o_byte_input)) // R07
		else $error("write captured while write snoop off");

	// read enable is independent of the write enable
	a_read_disabled: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_bus_valid && !i_bus_write && !o_target[`CRCS_TGT_RD_EN_BIT]
		&& !i_in_wr |=> $stable(o_byte_input)) // R07
		else $error("read captured while read snoop off");

	a_explicit_wins: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_in_wr |=> o_byte_input == $past(i_in_data)) // R11
		else $error("explicit byte lost to snoop capture");

	a_seed_readback: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_res_wr ##1 !i_res_wr |-> o_result == $past(i_res_data, 1)) // R12
		else $error("seed value not read back");

	a_target_readback: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_tgt_wr |=> o_target == $past(i_tgt_data)) // R12
		else $error("target value not read back");

endmodule // crcs_top

`default_nettype wire

/* tb_top.sv */
// self-checking bench of the crc calculator and its bus snoop
`timescale 1ns/1ps
`default_nettype none
`include "crcs_map.svh"

module tb_top;
	logic i_clk = 1'b0; // 125 MHz
	logic nrst = 1'b0, poly = 1'b0, in_wr = 1'b0, res_wr = 1'b0;
	logic tgt_wr = 1'b0, go = 1'b0, wr = 1'b0;
	logic [7:0] in_data = 8'h00, last_byte = 8'h00; // byte model
	logic [15:0] res_data = 16'h0000, tgt_data = 16'h0000;
	logic [15:0] data = 16'h0000, crc_exp = 16'h0000; // code model
	logic [13:0] addr = 14'h0000;
	logic bv, bw, busy;
	logic [13:0] ba;
	logic [15:0] bwd, brd, o_result, o_target;
	logic [7:0] o_byte;
	int failures = 0;
	int n_tests = 0;

	// free-running clock
	always #4 i_clk = ~i_clk;

	crcs_bus_model crcs_bus_model_inst (.i_clk(i_clk), .i_go(go),
		.i_write(wr), .i_addr(addr), .i_data(data), .o_bus_valid(bv),
		.o_bus_write(bw), .o_bus_addr(ba), .o_bus_wdata(bwd),
		.o_bus_rdata(brd));
	crcs_top crcs_top_inst (.i_clk(i_clk), .i_nrst(nrst),
		.i_poly_sel(poly), .i_in_wr(in_wr), .i_in_data(in_data),
		.i_res_wr(res_wr), .i_res_data(res_data), .i_tgt_wr(tgt_wr),
		.i_tgt_data(tgt_data), .i_bus_valid(bv), .i_bus_write(bw),
		.i_bus_addr(ba), .i_bus_wdata(bwd), .i_bus_rdata(brd),
		.o_byte_input(o_byte), .o_result(o_result), .o_target(o_target),
		.o_busy(busy));

	// msb-first reference step, no reflection
	function automatic logic [15:0] crc_ref(input logic [15:0] c,
		input logic [7:0] d, input logic p);
		logic [15:0] pl;
		pl = p ? `CRCS_POLY_CRC16 : `CRCS_POLY_CCITT;
		c = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) c = c[15] ? ((c << 1) ^ pl) : (c << 1);
		return c;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// seed the result register
	task automatic seed(input logic [15:0] v);
		@(posedge i_clk) begin res_wr <= 1'b1; res_data <= v; end
		@(posedge i_clk) res_wr <= 1'b0;
		#1 chk(o_result, v);
		crc_exp = v;
	endtask

	// load the snoop target, bits 15/14 enable write/read capture
	task automatic target(input logic [15:0] v);
		@(posedge i_clk) begin tgt_wr <= 1'b1; tgt_data <= v; end
		@(posedge i_clk) tgt_wr <= 1'b0;
		#1 chk(o_target, v);
	endtask

	// explicit byte: busy one cycle, code two cycles after the write
	task automatic explicit(input logic [7:0] d, input logic p);
		@(posedge i_clk) begin in_wr <= 1'b1; in_data <= d; poly <= p; end
		@(posedge i_clk) in_wr <= 1'b0;
		#1 chk({8'h00, o_byte}, {8'h00, d});
		chk({15'h0000, busy}, 16'h0001);
		@(posedge i_clk) #1 chk({15'h0000, busy}, 16'h0000);
		crc_exp = crc_ref(crc_exp, d, p);
		last_byte = d;
		chk(o_result, crc_exp);
	endtask

	// two bytes on back-to-back cycles; the second keeps the fold going
	task automatic burst(input logic [7:0] d0, input logic [7:0] d1);
		@(posedge i_clk) begin in_wr <= 1'b1; in_data <= d0; end
		@(posedge i_clk) in_data <= d1;
		@(posedge i_clk) in_wr <= 1'b0;
		crc_exp = crc_ref(crc_exp, d0, poly);
		#1 chk({8'h00, o_byte}, {8'h00, d1});
		chk({15'h0000, busy}, 16'h0001);
		chk(o_result, crc_exp);
		@(posedge i_clk) #1 chk({15'h0000, busy}, 16'h0000);
		crc_exp = crc_ref(crc_exp, d1, poly);
		last_byte = d1;
		chk(o_result, crc_exp);
	endtask

	// one bus access; hit says whether a capture is due
	task automatic snoop(input logic w, input logic [13:0] a,
		input logic [15:0] d, input logic hit);
		@(posedge i_clk) begin go <= 1'b1; wr <= w; addr <= a; data <= d; end
		@(posedge i_clk) go <= 1'b0;
		repeat (2) @(posedge i_clk);
		if (hit) begin
			crc_exp = crc_ref(crc_exp, d[7:0], poly);
			last_byte = d[7:0];
		end
		#1 chk({8'h00, o_byte}, {8'h00, last_byte});
		chk(o_result, crc_exp);
	endtask

	// snoop hit in the same cycle as an explicit write: capture dropped
	task automatic collide(input logic [7:0] d);
		@(posedge i_clk) begin go <= 1'b1; wr <= 1'b1; addr <= 14'h0040;
			data <= 16'h00EE; end
		@(posedge i_clk) begin go <= 1'b0; in_wr <= 1'b1; in_data <= d; end
		@(posedge i_clk) in_wr <= 1'b0;
		repeat (3) @(posedge i_clk);
		crc_exp = crc_ref(crc_exp, d, poly);
		#1 chk({8'h00, o_byte}, {8'h00, d});
		chk(o_result, crc_exp);
	endtask

	// watchdog against a hung run
	initial begin
		#100000;
		failures++;
		print_verdict();
	end

	// main sequence
	initial begin
		repeat (2) @(posedge i_clk);
		nrst <= 1'b1;
		#1 chk({8'h00, o_byte}, {8'h00, `CRCS_RST_BYTE});
		chk(o_result, `CRCS_RST_RESULT);
		chk(o_target, `CRCS_RST_TARGET);
		seed(16'hFFFF);
		explicit(8'h31, 1'b0);
		explicit(8'h32, 1'b1);
		burst(8'h10, 8'hF0);
		target(16'hC040);
		snoop(1'b1, 14'h0040, 16'hA55A, 1'b1);
		snoop(1'b0, 14'h0040, 16'h12C3, 1'b1);
		snoop(1'b1, 14'h0041, 16'h0077, 1'b0);
		target(16'h4040);
		snoop(1'b1, 14'h0040, 16'h0066, 1'b0);
		target(16'h8040);
		snoop(1'b0, 14'h0040, 16'h0033, 1'b0);
		target(16'hC020);
		snoop(1'b1, 14'h0020, 16'h0055, 1'b0);
		target(16'hC021);
		snoop(1'b1, 14'h0021, 16'h0044, 1'b1);
		target(16'hC040);
		collide(8'h9D);
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
